// ### lp_device.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Controller drives request low to ask stop
// - Device acks low after preparing clock removal
// - Clock needed low accepts, high denies
// - Clock off only after accepted acknowledge
// - Controller restarts clock, then raises request
// - Request high makes device raise acknowledge
// - Denied requests still complete full handshake
// - Bus domain denies while busy, accepts idle
// - Memory domains always accept after preparation
// - Dynamic memory enters self-refresh before ack
// - Three independent per-domain handshake interfaces
// - No dynamic access while its clocks stopped
// - Memory clocks frozen in self-refresh, forced off at its ack, else per enable
// - Synchronous mode drops crossing synchroniser stages
// - Four gated per-device memory output clocks
// - Active-low resets asserted synchronously, per domain
// - Reset release synchronised to its clock
// - User status readable, not synchronised internally
// - User config driven from write-only register
// - Clock enable and mask reset to tie-offs
// - Both sync ties equal; bus-faster tie gated by the sync tie
module lp_device #(
   parameter int unsigned SR_CYCLES = lp_pkg::SELF_REFRESH_CYCLES
) (
   input  wire logic                         sys_clk_i,
   input  wire logic                         reset_i,
   lp_if.device                              lp,
   input  wire logic [lp_pkg::OUTCLK_N-1:0]  clk_out_en_i,
   input  wire logic                         ustatus_rd_i,
   input  wire logic                         ucfg_wr_i,
   input  wire logic [lp_pkg::USER_W-1:0]    ucfg_wdata_i,
   output logic      [lp_pkg::USER_W-1:0]    ustatus_rdata_o,
   output logic      [lp_pkg::OUTCLK_N-1:0]  mem_clk_out_o,
   output logic                              cke_o,
   output logic                              dqm_o,
   output logic                              self_refresh_o
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Prepare counter is eight bits wide and must count at least once
   if (SR_CYCLES < 1 || SR_CYCLES > 255) begin : g_bad_sr_cycles
      $error("SR_CYCLES out of range");
   end
   // Handshake logic is written for exactly three domains
   if (lp_pkg::NUM_DOM != 3) begin : g_bad_num_dom
      $error("NUM_DOM must be 3");
   end
   // Domain indices must fit the handshake vectors
   if (lp_pkg::DOM_BUS >= lp_pkg::NUM_DOM || lp_pkg::DOM_DYN >= lp_pkg::NUM_DOM ||
       lp_pkg::DOM_STAT >= lp_pkg::NUM_DOM) begin : g_bad_dom_index
      $error("Domain index out of range");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // One handshake state per domain, packed so it fits the state struct
   typedef lp_pkg::hs_state_t [lp_pkg::NUM_DOM-1:0] hs_arr_t;

   typedef struct packed {
      logic [lp_pkg::NUM_DOM-1:0]   req_s1;
      logic [lp_pkg::NUM_DOM-1:0]   req_s2;
      hs_arr_t                      hs;
      logic [lp_pkg::NUM_DOM-1:0]   ack_n;
      logic [lp_pkg::NUM_DOM-1:0]   needed;
      logic [7:0]                   cnt;
      logic [1:0]                   brst;     // Bus reset release synchroniser
      logic [1:0]                   mrst;     // Memory reset release synchroniser
      logic [lp_pkg::USER_W-1:0]    ucfg;
      logic [lp_pkg::USER_W-1:0]    ustat;
      logic [lp_pkg::OUTCLK_N-1:0]  clk_en;
      logic                         cke;
      logic                         dqm;
      logic                         sr;
   } dev_t;

   dev_t st;
   dev_t next_st;
   logic [lp_pkg::NUM_DOM-1:0] req_n;
   logic                       sync_mode;

   // -------------------------------------------------------------
   // Request path and handshake
   // -------------------------------------------------------------
   // Synchronous mode bypasses the crossing stages
   assign sync_mode = lp.sync_mode_a & lp.sync_mode_m;
   assign req_n     = sync_mode ? lp.stop_req_n : st.req_s2;

   // Next-state logic for all domains
   always_comb begin
      // Synchronisers shift, user status sampled every cycle
      next_st        = st;
      next_st.req_s1 = lp.stop_req_n;
      next_st.req_s2 = st.req_s1;
      next_st.brst   = {st.brst[0], 1'b1};
      next_st.mrst   = {st.mrst[0], 1'b1};
      next_st.ustat  = lp.user_status;
      if (ucfg_wr_i) begin
         next_st.ucfg = ucfg_wdata_i;
      end
      // Independent handshake per domain
      for (int d = 0; d < lp_pkg::NUM_DOM; d++) begin
         case (st.hs[d])
            lp_pkg::HS_RUN: begin
               if (!req_n[d]) begin
                  next_st.hs[d] = lp_pkg::HS_PREP;
                  if (d == lp_pkg::DOM_DYN) begin
                     next_st.cnt = 8'(SR_CYCLES);
                     next_st.sr  = 1'b1;
                     next_st.cke = 1'b0;
                  end
               end
            end
            lp_pkg::HS_PREP: begin
               if (d != lp_pkg::DOM_DYN || st.cnt <= 8'h01) begin
                  next_st.hs[d]    = lp_pkg::HS_ACKED;
                  next_st.ack_n[d] = 1'b0;
                  if (d == lp_pkg::DOM_BUS) begin
                     next_st.needed[d] = lp.bus_busy;
                  end else begin
                     next_st.needed[d] = 1'b0;
                  end
                  if (d == lp_pkg::DOM_DYN) begin
                     next_st.clk_en = '0;
                  end
               end else begin
                  next_st.cnt = st.cnt - 8'h01;
               end
            end
            lp_pkg::HS_ACKED: begin
               if (req_n[d]) begin
                  next_st.hs[d] = lp_pkg::HS_RELEASE;
               end
            end
            lp_pkg::HS_RELEASE: begin
               next_st.hs[d]     = lp_pkg::HS_RUN;
               next_st.ack_n[d]  = 1'b1;
               next_st.needed[d] = 1'b1;
               if (d == lp_pkg::DOM_DYN) begin
                  next_st.sr  = 1'b0;
                  next_st.cke = 1'b1;
               end
            end
            default: next_st.hs[d] = lp_pkg::HS_RUN;
         endcase
      end
      // Output clocks follow the device requests outside self-refresh
      if (!st.sr) begin
         next_st.clk_en = clk_out_en_i;
      end
      // Bus domain waits for its reset release to pass the synchroniser
      if (!st.brst[1]) begin
         next_st.hs = st.hs;
      end
      // Memory domain waits likewise before its outputs may move
      if (!st.mrst[1]) begin
         next_st.cke    = st.cke;
         next_st.dqm    = st.dqm;
         next_st.sr     = st.sr;
         next_st.clk_en = st.clk_en;
         next_st.cnt    = st.cnt;
      end
      // Bus domain reset
      if (reset_i || !lp.bus_reset_n) begin
         next_st.brst = 2'b00;
         for (int d = 0; d < lp_pkg::NUM_DOM; d++) begin
            next_st.hs[d] = lp_pkg::HS_RUN;
         end
         next_st.ack_n  = '1;
         next_st.needed = '1;
         next_st.ucfg   = lp_pkg::CONFIG_RESET;
      end
      // Memory domain reset
      if (reset_i || !lp.mem_reset_n) begin
         next_st.mrst   = 2'b00;
         next_st.cke    = lp.cke_init;
         next_st.dqm    = lp.dqm_init;
         next_st.sr     = 1'b0;
         next_st.clk_en = '0;
         next_st.cnt    = 8'h00;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      st <= next_st;
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign lp.stop_ack_n   = st.ack_n;
   assign lp.clk_needed   = st.needed;
   assign lp.user_config  = st.ucfg;
   assign ustatus_rdata_o = st.ustat;
   assign mem_clk_out_o   = st.clk_en;
   assign cke_o           = st.cke;
   assign dqm_o           = st.dqm;
   assign self_refresh_o  = st.sr;

   // Inputs with no function in this single-clock model
   logic unused;
   assign unused = ustatus_rd_i ^ lp.bus_faster_sync_tie;
endmodule // lp_device

// ### lp_pkg.sv
package lp_pkg;
   // ----------------------------------------------------------------
   // Domain indices
   // ----------------------------------------------------------------
   localparam int unsigned DOM_BUS  = 0;
   localparam int unsigned DOM_DYN  = 1;
   localparam int unsigned DOM_STAT = 2;
   localparam int unsigned NUM_DOM  = 3;

   // ----------------------------------------------------------------
   // Timing figures (ns) and counts (cycles of sys_clk_i)
   // ----------------------------------------------------------------
   localparam int unsigned SELF_REFRESH_ENTRY_NS = 200;
   localparam int unsigned CLK_PERIOD_NS         = 100;
   localparam int unsigned SELF_REFRESH_CYCLES   =
      (SELF_REFRESH_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STATIC_PREP_CYCLES    = 1;
   localparam int unsigned SYNC_STAGES           = 2;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int unsigned USER_W       = 8;
   localparam int unsigned OUTCLK_N     = 4;
   localparam logic [7:0]  CONFIG_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Controller register map (word offsets on the plain port)
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0; // [2:0] stop want per domain
   localparam logic [3:0] REG_STATUS = 4'h1; // [2:0] ack_n, [5:3] active, [8:6] stopped
   localparam logic [3:0] REG_USTAT  = 4'h2; // User status to device
   localparam logic [3:0] REG_UCFG   = 4'h3; // User config from device
   localparam logic [3:0] REG_TIES   = 4'h4; // [0] sync, [1] bus faster, [2] busy in
   localparam int unsigned ST_ACK_LSB    = 0;
   localparam int unsigned ST_ACTIVE_LSB = 3;
   localparam int unsigned ST_STOP_LSB   = 6;

   // Per-domain handshake states of the device end
   typedef enum logic [2:0] {
      HS_RUN     = 3'b000,
      HS_PREP    = 3'b001,
      HS_ACKED   = 3'b010,
      HS_RELEASE = 3'b011
   } hs_state_t;

   // Per-domain states of the clock controller end
   typedef enum logic [1:0] {
      CC_RUN   = 2'b00,
      CC_REQ   = 2'b01,
      CC_OFF   = 2'b10,
      CC_WAKE  = 2'b11
   } cc_state_t;
endpackage

// ### lp_if.sv
`timescale 1ns/1ps
interface lp_if;
   logic [lp_pkg::NUM_DOM-1:0] stop_req_n;      // Clock stop request, low = stop
   logic [lp_pkg::NUM_DOM-1:0] stop_ack_n;      // Acknowledge, low = acked
   logic [lp_pkg::NUM_DOM-1:0] clk_needed;      // High = request denied
   logic                       sync_mode_a;     // Synchronous-mode tie, bus side
   logic                       sync_mode_m;     // Synchronous-mode tie, memory side
   logic                       bus_faster_sync_tie;
   logic [lp_pkg::USER_W-1:0]  user_status;     // To device
   logic [lp_pkg::USER_W-1:0]  user_config;     // From device
   logic                       bus_busy;        // Bus transfer in progress
   logic                       cke_init;        // Tie-off for memory clock enable
   logic                       dqm_init;        // Tie-off for data mask
   logic                       bus_reset_n;     // Bus domain reset, active low
   logic                       mem_reset_n;     // Memory domain reset, active low

   modport device (
      input  stop_req_n, sync_mode_a, sync_mode_m, bus_faster_sync_tie,
             user_status, bus_busy, cke_init, dqm_init, bus_reset_n, mem_reset_n,
      output stop_ack_n, clk_needed, user_config
   );
   modport controller (
      output stop_req_n, sync_mode_a, sync_mode_m, bus_faster_sync_tie,
             user_status, bus_busy, cke_init, dqm_init, bus_reset_n, mem_reset_n,
      input  stop_ack_n, clk_needed, user_config
   );
endinterface

// ### lp_controller.sv
`timescale 1ns/1ps
module lp_controller (
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_i,
   lp_if.controller                        lp,
   input  wire logic [3:0]                 addr_i,
   input  wire logic [31:0]                wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [31:0]                rdata_o,
   output logic      [lp_pkg::NUM_DOM-1:0] clk_gate_en_o
);
   typedef lp_pkg::cc_state_t [lp_pkg::NUM_DOM-1:0] cc_arr_t;

   typedef struct packed {
      cc_arr_t                    cc;
      logic [lp_pkg::NUM_DOM-1:0] want;
      logic [lp_pkg::NUM_DOM-1:0] req_n;
      logic [lp_pkg::NUM_DOM-1:0] clk_en;
      logic [2:0]                 ties;
      logic [lp_pkg::USER_W-1:0]  ustat;
      logic [31:0]                rdata;
   } ctl_t;

   ctl_t st;
   ctl_t next_st;

   // -------------------------------------------------------------
   // Register port and per-domain request sequencing
   // -------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_st.rdata = 32'h0000_0000;
      if (wr_i) begin
         case (addr_i)
            lp_pkg::REG_CTRL:  next_st.want  = wdata_i[2:0];
            lp_pkg::REG_USTAT: next_st.ustat = wdata_i[7:0];
            lp_pkg::REG_TIES:  next_st.ties  = wdata_i[2:0];
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            lp_pkg::REG_CTRL:   next_st.rdata = {29'h0, st.want};
            lp_pkg::REG_STATUS: next_st.rdata = {23'h0, ~st.clk_en, lp.clk_needed, lp.stop_ack_n};
            lp_pkg::REG_USTAT:  next_st.rdata = {24'h0, st.ustat};
            lp_pkg::REG_UCFG:   next_st.rdata = {24'h0, lp.user_config};
            lp_pkg::REG_TIES:   next_st.rdata = {29'h0, st.ties};
            default:            next_st.rdata = 32'h0000_0000;
         endcase
      end
      for (int d = 0; d < lp_pkg::NUM_DOM; d++) begin
         case (st.cc[d])
            lp_pkg::CC_RUN: if (st.want[d]) begin
               next_st.req_n[d] = 1'b0;
               next_st.cc[d]    = lp_pkg::CC_REQ;
            end
            lp_pkg::CC_REQ: if (!lp.stop_ack_n[d]) begin
               if (!lp.clk_needed[d]) begin
                  next_st.clk_en[d] = 1'b0;
                  next_st.cc[d]     = lp_pkg::CC_OFF;
               end else begin
                  next_st.req_n[d]  = 1'b1;
                  next_st.want[d]   = 1'b0;
                  next_st.cc[d]     = lp_pkg::CC_WAKE;
               end
            end
            lp_pkg::CC_OFF: if (!st.want[d]) begin
               next_st.clk_en[d] = 1'b1;
               next_st.cc[d]     = lp_pkg::CC_WAKE;
            end
            lp_pkg::CC_WAKE: begin
               next_st.req_n[d] = 1'b1;
               if (lp.stop_ack_n[d] && st.req_n[d]) next_st.cc[d] = lp_pkg::CC_RUN;
            end
            default: next_st.cc[d] = lp_pkg::CC_RUN;
         endcase
      end
      if (reset_i) begin
         for (int d = 0; d < lp_pkg::NUM_DOM; d++) next_st.cc[d] = lp_pkg::CC_RUN;
         next_st.want   = '0;
         next_st.req_n  = '1;
         next_st.clk_en = '1;
         next_st.ties   = 3'h1;
         next_st.ustat  = 8'h00;
         next_st.rdata  = 32'h0000_0000;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      st <= next_st;
   end

   // Drive ties and requests toward the device
   assign lp.stop_req_n          = st.req_n;
   assign lp.sync_mode_a         = st.ties[0];
   assign lp.sync_mode_m         = st.ties[0];
   assign lp.bus_faster_sync_tie = st.ties[1] & st.ties[0];
   assign lp.bus_busy            = st.ties[2];
   assign lp.user_status         = st.ustat;
   assign lp.cke_init            = 1'b1;
   assign lp.dqm_init            = 1'b1;
   assign lp.bus_reset_n         = ~reset_i;
   assign lp.mem_reset_n         = ~reset_i;
   assign rdata_o                = st.rdata;
   assign clk_gate_en_o          = st.clk_en;
endmodule // lp_controller

// ### lp_monitor.sv
`timescale 1ns/1ps
module lp_monitor (
   input wire logic                       sys_clk_i,
   input wire logic                       reset_i,
   input wire logic [lp_pkg::NUM_DOM-1:0] stop_req_n_i,
   input wire logic [lp_pkg::NUM_DOM-1:0] stop_ack_n_i,
   input wire logic [lp_pkg::NUM_DOM-1:0] clk_needed_i,
   input wire logic                       bus_busy_i
);
   // ----------------------------------------------------------------
   // Handshake checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // Dynamic stop request and its accepted answer
   sequence s_dyn_req;
      $fell(stop_req_n_i[1]);
   endsequence
   sequence s_dyn_ack;
      !stop_ack_n_i[1] && !clk_needed_i[1];
   endsequence

   a_dyn_accept: assert property (s_dyn_req |-> ##[1:20] s_dyn_ack)
      else $error("dynamic stop request not accepted in time");
   a_ack_needs_req: assert property ((($past(stop_ack_n_i) & ~stop_ack_n_i & stop_req_n_i) == 3'h0))
      else $error("acknowledge fell without a request");
   a_ack_release: assert property ($rose(stop_req_n_i[0]) |-> ##[1:6] stop_ack_n_i[0])
      else $error("acknowledge not raised after request release");
   a_ack_holds: assert property ((!stop_req_n_i[2] && !stop_ack_n_i[2]) |=> !stop_ack_n_i[2])
      else $error("acknowledge released while request still low");
   a_bus_deny: assert property ($fell(stop_ack_n_i[0]) && $past(bus_busy_i) && bus_busy_i
      |-> clk_needed_i[0])
      else $error("busy bus domain accepted a stop");
   a_bus_accept: assert property ($fell(stop_ack_n_i[0]) && !$past(bus_busy_i) && !bus_busy_i
      |-> !clk_needed_i[0])
      else $error("idle bus domain denied a stop");
   a_stat_accept: assert property ($fell(stop_ack_n_i[2]) |-> !clk_needed_i[2])
      else $error("static domain denied a stop");
   a_needed_hold: assert property (!stop_ack_n_i[0] && !$past(stop_ack_n_i[0])
      |-> $stable(clk_needed_i[0]))
      else $error("clock needed changed while acknowledged");
   a_req_completes: assert property ($rose(stop_req_n_i[1]) |-> !stop_ack_n_i[1])
      else $error("request raised before acknowledge");
   a_reset_idle: assert property (disable iff (1'b0) reset_i
      |=> (stop_ack_n_i == 3'h7) && (clk_needed_i == 3'h7))
      else $error("handshake outputs not idle after reset");
endmodule // lp_monitor

// ### low_power_clock_handshake_tb.sv
`timescale 1ns/1ps
module low_power_clock_handshake_tb;
   logic        sys_clk_i, reset_i, wr_i, rd_i, ucfg_wr_i;
   logic [3:0]  addr_i, clk_out_en_i, mem_clk_out_o;
   logic [31:0] wdata_i, rdata_o, d;
   logic [7:0]  ucfg_wdata_i, ustatus_rdata_o;
   logic [2:0]  clk_gate_en_o;
   logic        cke_o, dqm_o, self_refresh_o;
   int          mismatches, tests_run;

   lp_if lp ();
   lp_device #(.SR_CYCLES(2)) i_lp_device (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .lp(lp),
      .clk_out_en_i(clk_out_en_i), .ustatus_rd_i(1'b0), .ucfg_wr_i(ucfg_wr_i), .ucfg_wdata_i(ucfg_wdata_i),
      .ustatus_rdata_o(ustatus_rdata_o), .mem_clk_out_o(mem_clk_out_o), .cke_o(cke_o), .dqm_o(dqm_o),
      .self_refresh_o(self_refresh_o));
   lp_controller i_lp_controller (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .lp(lp), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clk_gate_en_o(clk_gate_en_o));
   lp_monitor i_lp_monitor (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .stop_req_n_i(lp.stop_req_n),
      .stop_ack_n_i(lp.stop_ack_n), .clk_needed_i(lp.clk_needed), .bus_busy_i(lp.bus_busy));

   // ----------------------------------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
   endtask

   // Poll status until its low nine bits match, bounded
   task automatic wait_st(input logic [8:0] exp);
      for (int i = 0; i < 60; i++) begin
         rd(lp_pkg::REG_STATUS, d);
         if (d[8:0] === exp) return;
      end
      chk(d, {23'h0, exp});
      final_report();
   endtask

   // Stop one domain, check the accepted state, then wake it
   task automatic stop_dom(input int unsigned dm);
      logic [2:0] b;
      b = 3'h1 << dm;
      wr(lp_pkg::REG_CTRL, {29'h0, b});
      wait_st({b, 3'h7 & ~b, 3'h7 & ~b});
      chk(clk_gate_en_o, 3'h7 & ~b);
      if (dm == lp_pkg::DOM_DYN) begin
         chk(self_refresh_o, 1'b1);
         chk(mem_clk_out_o, 4'h0);
      end
      wr(lp_pkg::REG_CTRL, 32'h0);
      wait_st(9'h03f);
      chk(clk_gate_en_o, 3'h7);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; ucfg_wr_i = 1'b0;
      addr_i = 4'h0; wdata_i = 32'h0; ucfg_wdata_i = 8'h00; clk_out_en_i = 4'h5;
      repeat (6) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      #1;
      chk(lp.stop_ack_n, 3'h7);
      chk(lp.clk_needed, 3'h7);
      chk(lp.user_config, lp_pkg::CONFIG_RESET);
      chk(cke_o, lp.cke_init);
      chk(dqm_o, lp.dqm_init);
      chk(mem_clk_out_o, 4'h5);
      chk({lp.sync_mode_a, lp.sync_mode_m}, 2'h3);
      rd(lp_pkg::REG_TIES, d);
      chk(d[2:0], 3'h1);
      // User config write and status path
      @(posedge sys_clk_i);
      ucfg_wr_i    <= 1'b1;
      ucfg_wdata_i <= 8'ha5;
      @(posedge sys_clk_i);
      ucfg_wr_i    <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk(lp.user_config, 8'ha5);
      chk(ustatus_rdata_o, 8'h00);
      rd(lp_pkg::REG_UCFG, d);
      chk(d[7:0], 8'ha5);
      // User status from the far end, read back unsynchronised
      wr(lp_pkg::REG_USTAT, 32'h3c);
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk(ustatus_rdata_o, 8'h3c);
      // Accepted stops, each domain alone, synchronous mode
      for (int dm = 0; dm < 3; dm++) stop_dom(dm);
      // Bus domain busy: denial completes the handshake
      wr(lp_pkg::REG_TIES, 32'h5);
      wr(lp_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 40 && lp.stop_ack_n[0] !== 1'b0; i++) @(posedge sys_clk_i);
      #1;
      if (lp.stop_ack_n[0] !== 1'b0) begin
         chk(lp.stop_ack_n[0], 1'b0);
         final_report();
      end
      chk(lp.stop_ack_n[0], 1'b0);
      chk(lp.clk_needed[0], 1'b1);
      chk(clk_gate_en_o, 3'h7);
      wait_st(9'h03f);
      rd(lp_pkg::REG_CTRL, d);
      chk(d[2:0], 3'h0);
      // Asynchronous mode: extra synchroniser stages still accept
      wr(lp_pkg::REG_TIES, 32'h0);
      stop_dom(lp_pkg::DOM_STAT);
      stop_dom(lp_pkg::DOM_DYN);
      wr(lp_pkg::REG_TIES, 32'h1);
      clk_out_en_i <= 4'ha;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk(mem_clk_out_o, 4'ha);
      final_report();
   end
endmodule // low_power_clock_handshake_tb
